// File: hw/eag_effective_address_generator.sv
`timescale 1ns/10ps
module eag_effective_address_generator (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst,
  input  wire logic               i_start,
  input  wire eag_pkg::eag_mode_e i_mode,
  input  wire logic               i_is_branch,
  input  wire logic [7:0]         i_op_lo,
  input  wire logic [7:0]         i_op_hi,
  input  wire logic [7:0]         i_idx_x,
  input  wire logic [7:0]         i_idx_y,
  input  wire logic [15:0]        i_pc_next,
  input  wire logic               i_mem_rvalid,
  input  wire logic [7:0]         i_mem_rdata,
  output logic                    o_mem_req,
  output logic [15:0]             o_mem_addr,
  output logic                    o_ea_valid,
  output logic [15:0]             o_ea,
  output logic                    o_load_pc,
  output logic                    o_ptr_pending,
  output logic                    o_mode_err
);
  import eag_pkg::*;

  eag_state_e  state_q;
  eag_mode_e   mode_q;
  logic [15:0] ptr_q;
  logic [7:0]  lo_q;
  logic        carry_q;
  logic [8:0]  sum_lo;
  logic        take;
  logic        rd_lo;
  logic        rd_hi;

  function automatic logic [15:0] ptr_next(input logic [15:0] p,
                                           input logic zp);
    if (zp) begin
      ptr_next = {EAG_PAGE_ZERO, p[7:0] + 8'h01};
    end else begin
      ptr_next = p + 16'h0001;
    end
  endfunction

  function automatic logic [15:0] base_sum(input logic [7:0] hi,
                                           input logic [7:0] lo,
                                           input logic [7:0] idx);
    base_sum = {hi, lo} + {8'h00, idx};
  endfunction

  function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                             input logic [7:0]  off);
    rel_target = pc + {{8{off[7]}}, off};
  endfunction

  function automatic logic rel_taken(input eag_mode_e m,
                                     input logic      br);
    rel_taken = (m == EAG_MODE_REL) && br;
  endfunction

  function automatic logic is_ptr_mode(input eag_mode_e m);
    case (m)
      EAG_MODE_IND_X, EAG_MODE_IND_Y, EAG_MODE_JMP_IND: begin
        is_ptr_mode = 1'b1;
      end
      default: begin
        is_ptr_mode = 1'b0;
      end
    endcase
  endfunction

  function automatic logic gives_ea(input eag_mode_e m,
                                    input logic      br);
    gives_ea = (m == EAG_MODE_ABS_X) || (m == EAG_MODE_ABS_Y)
               || rel_taken(m, br); // implied gives none
  endfunction

  function automatic logic mode_refused(input eag_mode_e m,
                                        input logic      br);
    case (m)
      EAG_MODE_REL: begin
        mode_refused = !br;
      end
      EAG_MODE_ABS_X, EAG_MODE_ABS_Y, EAG_MODE_IMPLIED,
      EAG_MODE_IND_X, EAG_MODE_IND_Y, EAG_MODE_JMP_IND: begin
        mode_refused = 1'b0;
      end
      default: begin
        mode_refused = 1'b1;
      end
    endcase
  endfunction

  assign sum_lo = {1'b0, i_mem_rdata} + {1'b0, i_idx_y};
  assign take   = i_start && (state_q == EAG_ST_IDLE);
  assign rd_lo  = (state_q == EAG_ST_WAITL) && i_mem_rvalid;
  assign rd_hi  = (state_q == EAG_ST_WAITH) && i_mem_rvalid;
  assign o_mem_req = (state_q == EAG_ST_PTR_L) || (state_q == EAG_ST_PTR_H);
  assign o_mem_addr = ptr_q;
  assign o_ptr_pending = (state_q != EAG_ST_IDLE);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= EAG_ST_IDLE;
    end else begin
      case (state_q)
        EAG_ST_IDLE: begin
          if (take && is_ptr_mode(i_mode)) begin
            state_q <= EAG_ST_PTR_L;
          end
        end
        EAG_ST_PTR_L: begin
          state_q <= EAG_ST_WAITL;
        end
        EAG_ST_WAITL: begin
          if (i_mem_rvalid) begin
            state_q <= EAG_ST_PTR_H;
          end
        end
        EAG_ST_PTR_H: begin
          state_q <= EAG_ST_WAITH;
        end
        EAG_ST_WAITH: begin
          if (i_mem_rvalid) begin
            state_q <= EAG_ST_IDLE;
          end
        end
        default: begin
          state_q <= EAG_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode_q <= EAG_MODE_IMPLIED;
    end else if (take) begin
      mode_q <= i_mode;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ptr_q <= EAG_ADDR_RST;
    end else if (take) begin
      case (i_mode)
        EAG_MODE_IND_X: begin
          ptr_q <= {EAG_PAGE_ZERO, i_op_lo + i_idx_x};
        end
        EAG_MODE_IND_Y: begin
          ptr_q <= {EAG_PAGE_ZERO, i_op_lo};
        end
        EAG_MODE_JMP_IND: begin
          ptr_q <= {i_op_hi, i_op_lo};
        end
        default: begin
          ptr_q <= ptr_q;
        end
      endcase
    end else if (rd_lo) begin
      ptr_q <= ptr_next(ptr_q, mode_q != EAG_MODE_JMP_IND);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lo_q    <= EAG_BYTE_RST;
      carry_q <= 1'b0;
    end else if (rd_lo) begin
      if (mode_q == EAG_MODE_IND_Y) begin
        lo_q    <= sum_lo[7:0];
        carry_q <= sum_lo[8];
      end else begin
        lo_q    <= i_mem_rdata;
        carry_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_ea <= EAG_ADDR_RST;
    end else if (take) begin
      case (i_mode)
        EAG_MODE_ABS_X: begin
          o_ea <= base_sum(i_op_hi, i_op_lo, i_idx_x);
        end
        EAG_MODE_ABS_Y: begin
          o_ea <= base_sum(i_op_hi, i_op_lo, i_idx_y);
        end
        EAG_MODE_REL: begin
          if (i_is_branch) begin
            o_ea <= rel_target(i_pc_next, i_op_lo);
          end
        end
        default: begin
          o_ea <= o_ea;
        end
      endcase
    end else if (rd_hi) begin
      o_ea <= {i_mem_rdata + {7'h00, carry_q}, lo_q};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_ea_valid <= 1'b0;
    end else begin
      o_ea_valid <= (take && gives_ea(i_mode, i_is_branch))
                    || rd_hi;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_load_pc <= 1'b0;
    end else begin
      o_load_pc <= (take && rel_taken(i_mode, i_is_branch))
                   || (rd_hi && (mode_q == EAG_MODE_JMP_IND));
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_mode_err <= 1'b0;
    end else begin
      o_mode_err <= take && mode_refused(i_mode, i_is_branch);
    end
  end

endmodule

// File: hw/eag_pkg.sv
package eag_pkg;

  typedef enum logic [2:0] {
    EAG_MODE_ABS_X   = 3'b000,
    EAG_MODE_ABS_Y   = 3'b001,
    EAG_MODE_IMPLIED = 3'b010,
    EAG_MODE_REL     = 3'b011,
    EAG_MODE_IND_X   = 3'b100,
    EAG_MODE_IND_Y   = 3'b101,
    EAG_MODE_JMP_IND = 3'b110
  } eag_mode_e;

  typedef enum logic [2:0] {
    EAG_ST_IDLE  = 3'b000,
    EAG_ST_PTR_L = 3'b001,
    EAG_ST_WAITL = 3'b010,
    EAG_ST_PTR_H = 3'b011,
    EAG_ST_WAITH = 3'b100
  } eag_state_e;

  localparam logic [7:0]  EAG_PAGE_ZERO = 8'h00;
  localparam logic [15:0] EAG_ADDR_RST  = 16'h0000;
  localparam logic [7:0]  EAG_BYTE_RST  = 8'h00;

endpackage

// File: test/eag_properties.sv
`timescale 1ns/10ps
module eag_chk (
  input wire logic               i_core_clk,
  input wire logic               i_rst,
  input wire logic               i_start,
  input wire logic               i_is_branch,
  input wire eag_pkg::eag_mode_e i_mode,
  input wire logic [7:0]         i_op_lo,
  input wire logic [7:0]         i_op_hi,
  input wire logic [7:0]         i_idx_x,
  input wire logic [7:0]         i_idx_y,
  input wire logic [15:0]        i_pc_next,
  input wire logic [15:0]        o_mem_addr,
  input wire logic [15:0]        o_ea,
  input wire logic               o_mem_req,
  input wire logic               o_ea_valid,
  input wire logic               o_load_pc,
  input wire logic               o_mode_err,
  input wire logic               o_ptr_pending
);
  import eag_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire        g  = i_start && !o_ptr_pending;
  wire [15:0] b  = {i_op_hi, i_op_lo};
  wire [15:0] ax = b + 16'(i_idx_x);
  wire [15:0] ay = b + 16'(i_idx_y);
  wire [15:0] rl = i_pc_next + {{8{i_op_lo[7]}}, i_op_lo};
  abs_x_a: assert property (g && i_mode == EAG_MODE_ABS_X |=>
    o_ea_valid && o_ea == $past(ax)) else $error("abs x wrong");
  abs_y_a: assert property (g && i_mode == EAG_MODE_ABS_Y |=>
    o_ea_valid && o_ea == $past(ay)) else $error("abs y wrong");
  implied_quiet_a: assert property (
    g && i_mode == EAG_MODE_IMPLIED |=> !(o_ea_valid || o_mem_req))
    else $error("implied not quiet");
  rel_refuse_a: assert property (
    g && i_mode == EAG_MODE_REL && !i_is_branch |=> o_mode_err && !o_ea_valid)
    else $error("relative not refused");
  rel_target_a: assert property (
    g && i_mode == EAG_MODE_REL && i_is_branch |=> o_load_pc && o_ea == $past(rl))
    else $error("branch target wrong");
  ind_x_ptr_a: assert property (g && i_mode == EAG_MODE_IND_X |=>
    o_mem_req && o_mem_addr == {8'h00, 8'($past(i_op_lo) + $past(i_idx_x))})
    else $error("pointer wrong");
  ind_y_ptr_a: assert property (g && i_mode == EAG_MODE_IND_Y |=>
    o_mem_req && o_ptr_pending && o_mem_addr == {8'h00, $past(i_op_lo)})
    else $error("pointer wrong");
  jmp_ptr_a: assert property (g && i_mode == EAG_MODE_JMP_IND |=>
    o_mem_req && o_mem_addr == $past(b)) else $error("jump pointer wrong");
endmodule
bind eag_effective_address_generator eag_chk i_chk (
  .i_core_clk    (i_core_clk),
  .i_rst         (i_rst),
  .i_start       (i_start),
  .i_is_branch   (i_is_branch),
  .i_mode        (i_mode),
  .i_op_lo       (i_op_lo),
  .i_op_hi       (i_op_hi),
  .i_idx_x       (i_idx_x),
  .i_idx_y       (i_idx_y),
  .i_pc_next     (i_pc_next),
  .o_mem_addr    (o_mem_addr),
  .o_ea          (o_ea),
  .o_mem_req     (o_mem_req),
  .o_ea_valid    (o_ea_valid),
  .o_load_pc     (o_load_pc),
  .o_mode_err    (o_mode_err),
  .o_ptr_pending (o_ptr_pending)
);

// File: test/eag_mem_model.sv
`timescale 1ns/10ps
module eag_mem_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_req,
  input  wire logic [15:0] i_addr,
  input  wire logic [1:0]  i_lat,
  output logic             o_rvalid = 0,
  output logic [7:0]       o_rdata = 0
);
  logic [15:0] a_q = 0;
  logic [1:0]  n_q = 0;
  wire  [15:0] a = i_req ? i_addr : a_q;
  always @(posedge i_core_clk) begin
    o_rvalid <= 0;
    o_rdata <= ~o_rdata; // idle data keeps moving
    if (i_req) {a_q, n_q} <= {i_addr, i_lat};
    else if (n_q != 0) n_q <= n_q - 1;
    if (i_req ? i_lat == 0 : n_q == 1) begin
      o_rvalid <= 1;
      o_rdata <= a[7:0] ^ a[15:8];
    end
  end
endmodule

// File: test/tb_effective_address_generator.sv
`timescale 1ns/10ps
module tb_effective_address_generator;
  import eag_pkg::*;
  logic clk = 0, rst = 1, st = 0, br = 0, rv, req, ev, lp, pp, me;
  logic [1:0] lat = 0;
  logic [7:0] lo = 0, hi = 0, x = 0, y = 0, rd, p;
  logic [15:0] pc = 0, ma, ea;
  logic [8:0] s;
  logic [31:0] r = 32'h115220fd;
  logic [17:0] q[$];
  int n_errors = 0, n_tests = 0;
  eag_mode_e md = EAG_MODE_ABS_X;
  eag_effective_address_generator i_dut (.i_core_clk(clk), .i_rst(rst),
    .i_start(st), .i_mode(md), .i_is_branch(br), .i_op_lo(lo), .i_op_hi(hi),
    .i_idx_x(x), .i_idx_y(y), .i_pc_next(pc), .i_mem_rvalid(rv),
    .i_mem_rdata(rd), .o_mem_req(req), .o_mem_addr(ma), .o_ea_valid(ev),
    .o_ea(ea), .o_load_pc(lp), .o_ptr_pending(pp), .o_mode_err(me));
  eag_mem_model i_mem (.i_core_clk(clk), .i_req(req), .i_addr(ma),
    .i_lat(lat), .o_rvalid(rv), .o_rdata(rd));
  function automatic logic [7:0] m(logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input string what, input logic [17:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #12.5 clk = ~clk;
  initial begin #500000; n_errors++; print_verdict; end
  always @(negedge clk) if (ev || me)
    check("ea", {me, lp, me ? 16'h0000 : ea},
      q.size() > 0 ? q.pop_front() : 18'h3_ffff);
  initial begin
    repeat (8) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 400; i++) begin
      r = lfsr(r);
      {br, lat, lo, hi, x} = r[26:0];
      md = eag_mode_e'(r[29:27]);
      y = r[7:0] ^ r[31:24];
      pc = r[31:16];
      if (i % 8 == 0) lo = 8'hff;
      p = lo + x;
      s = m({8'h0, lo}) + y;
      case (md)
        EAG_MODE_ABS_X: q.push_back({2'b00, {hi, lo} + 16'(x)});
        EAG_MODE_ABS_Y: q.push_back({2'b00, {hi, lo} + 16'(y)});
        EAG_MODE_IMPLIED: ;
        EAG_MODE_REL: q.push_back(br ? {2'b01, pc + {{8{lo[7]}}, lo}}
          : 18'h2_0000);
        EAG_MODE_IND_X: q.push_back({2'b00, m({8'h0, p + 8'h1}),
          m({8'h0, p})});
        EAG_MODE_IND_Y: q.push_back({2'b00, m({8'h0, lo + 8'h1})
          + 8'(s[8]), s[7:0]});
        EAG_MODE_JMP_IND: q.push_back({2'b01, m({hi, lo} + 16'h1),
          m({hi, lo})});
        default: q.push_back(18'h2_0000);
      endcase
      st = 1;
      @(negedge clk);
      while (pp) @(negedge clk);
    end
    st = 0;
    repeat (4) @(negedge clk);
    check("results left", 18'(q.size()), 18'h0_0000);
    print_verdict;
  end
endmodule
